// ===== hw/watchdog_regs_map.vh
`ifndef WATCHDOG_REGS_MAP_VH
`define WATCHDOG_REGS_MAP_VH

// register selection width on both serial front ends
`define REG_ADDR_W 5
`define REG_DATA_W 8

// register addresses
`define ADDR_RSVD_A 5'h00
`define ADDR_RSVD_B 5'h01
`define ADDR_GUARD 5'h02
`define ADDR_CONFIG 5'h03
`define ADDR_KICK 5'h04

// unlock key and reset values
`define GUARD_KEY 8'h5a
`define GUARD_RESET 8'h00
`define CONFIG_RESET 8'h09
`define KICK_RESET 1'h0
`define READ_ZERO 8'h00

// configuration field positions
`define CFG_EN_HI 7
`define CFG_EN_LO 6
`define CFG_TOUT_HI 5
`define CFG_TOUT_LO 3
`define CFG_WIN_HI 2
`define CFG_WIN_LO 0
`define CFG_DISABLE_CODE 2'h1
`define KICK_BIT 0

// period figures in milliseconds
`define MS_W 12
`define TOUT_MS_0 12'h050
`define TOUT_MS_1 12'h0a0
`define TOUT_MS_2 12'h140
`define TOUT_MS_3 12'h1e0
`define TOUT_MS_4 12'h320
`define TOUT_MS_5 12'h3e8
`define TOUT_MS_6 12'h7d0
`define TOUT_MS_7 12'hfa0
`define WIN_MS_0 12'h00a
`define WIN_MS_1 12'h028
`define WIN_MS_2 12'h050
`define WIN_MS_3 12'h078
`define WIN_MS_4 12'h0a0
`define WIN_MS_5 12'h0f0
`define WIN_MS_6 12'h140
`define WIN_MS_7 12'h190

// clock rate and millisecond prescaler
`define CLK_FREQ_HZ 200000000
`define MS_PER_SECOND 1000
`define PRESCALE_W 18

`endif

// ===== hw/watchdog_period_timer.v
`timescale 1ns/1ps
`include "watchdog_regs_map.vh"

module watchdog_period_timer #(
	parameter CYCLES_PER_MS = `CLK_FREQ_HZ / `MS_PER_SECOND,
	parameter PRESCALE_W = `PRESCALE_W,
	parameter MS_W = `MS_W
) (
	input wire sys_clk,
	input wire nrst,
	input wire run,
	input wire window_mode,
	input wire restart,
	input wire [MS_W-1:0] period_ms,
	input wire [MS_W-1:0] open_ms,
	output reg expired_q,
	output reg early_q,
	output reg window_open_q
);

	// last prescaler count of one millisecond, cut to the counter width
	localparam [31:0] PRESC_LAST_FULL = CYCLES_PER_MS - 1;
	localparam [PRESCALE_W-1:0] PRESC_LAST = PRESC_LAST_FULL[PRESCALE_W-1:0];
	localparam [MS_W-1:0] MS_ONE = {{(MS_W-1){1'b0}}, 1'b1};

	reg [PRESCALE_W-1:0] presc_q; // cycles within the current millisecond
	reg [MS_W-1:0] elapsed_q; // whole milliseconds since last restart
	wire ms_tick; // last cycle of a millisecond
	wire [MS_W-1:0] elapsed_inc; // elapsed count after this tick
	wire timeout_hit; // period used up without service

	assign ms_tick = (presc_q == PRESC_LAST);
	assign elapsed_inc = elapsed_q + MS_ONE;
	assign timeout_hit = ms_tick && (elapsed_inc >= period_ms);

	// counting runs on exact nominal figures, well inside the tolerance
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			presc_q <= {PRESCALE_W{1'b0}};
			elapsed_q <= {MS_W{1'b0}};
			expired_q <= 1'b0;
			early_q <= 1'b0;
			window_open_q <= 1'b0;
		end else if (!run) begin
			// disabled: hold everything clear so enabling starts fresh
			presc_q <= {PRESCALE_W{1'b0}};
			elapsed_q <= {MS_W{1'b0}};
			expired_q <= 1'b0;
			early_q <= 1'b0;
			window_open_q <= 1'b0;
		end else if (restart) begin
			// service restarts the count; too early in window mode is a fault
			presc_q <= {PRESCALE_W{1'b0}};
			elapsed_q <= {MS_W{1'b0}};
			expired_q <= 1'b0;
			early_q <= window_mode && (elapsed_q < open_ms);
			window_open_q <= !window_mode;
		end else if (timeout_hit) begin
			// no service in time: one pulse, then start a new period
			presc_q <= {PRESCALE_W{1'b0}};
			elapsed_q <= {MS_W{1'b0}};
			expired_q <= 1'b1;
			early_q <= 1'b0;
			window_open_q <= !window_mode;
		end else begin
			// plain counting
			presc_q <= ms_tick ? {PRESCALE_W{1'b0}} : presc_q + 1'b1;
			elapsed_q <= ms_tick ? elapsed_inc : elapsed_q;
			expired_q <= 1'b0;
			early_q <= 1'b0;
			window_open_q <= !window_mode || (elapsed_q >= open_ms);
		end
	end

endmodule

// ===== hw/watchdog_config_registers.v
`timescale 1ns/1ps
`include "watchdog_regs_map.vh"

module watchdog_config_registers #(
	parameter CYCLES_PER_MS = `CLK_FREQ_HZ / `MS_PER_SECOND
) (
	input wire sys_clk,
	input wire nrst,
	input wire regulator_one_power_on_reset_n,
	input wire window_mode,
	input wire spi_req,
	input wire spi_we,
	input wire [`REG_ADDR_W-1:0] spi_addr,
	input wire [`REG_DATA_W-1:0] spi_wdata,
	output reg spi_ack_q,
	output reg [`REG_DATA_W-1:0] spi_rdata_q,
	input wire i2c_req,
	input wire i2c_we,
	input wire [`REG_ADDR_W-1:0] i2c_addr,
	input wire [`REG_DATA_W-1:0] i2c_wdata,
	output reg i2c_ack_q,
	output reg [`REG_DATA_W-1:0] i2c_rdata_q,
	output reg config_unlocked_q,
	output reg watchdog_enabled_q,
	output wire watchdog_expired_q,
	output wire watchdog_early_q,
	output wire window_open_q
);

	// register state
	reg [`REG_DATA_W-1:0] guard_q; // access guard, regulator reset
	reg [`REG_DATA_W-1:0] guard_d;
	reg [`REG_DATA_W-1:0] config_q; // period config, supply reset
	reg [`REG_DATA_W-1:0] config_d;
	reg kick_q; // self-clearing service bit
	reg kick_d;

	// decoded write strobes, lock and enable
	wire spi_wr; // write from the spi front end
	wire i2c_wr; // write from the i2c front end
	wire unlocked; // guard holds the key right now
	wire run; // watchdog enabled by configuration

	// selected periods
	reg [`MS_W-1:0] tout_ms; // timeout mode period
	reg [`MS_W-1:0] win_ms; // window mode period
	wire [`MS_W-1:0] period_ms; // period in use
	wire [`MS_W-1:0] open_ms; // start of the open half

	// both front ends share one register file, no other path exists
	assign spi_wr = spi_req && spi_we;
	assign i2c_wr = i2c_req && i2c_we;

	// only the exact key opens the lock; reset value 0x00 keeps it shut
	assign unlocked = (guard_q == `GUARD_KEY);

	// only the code 01 stops the watchdog, reset value 00 leaves it running
	assign run = (config_q[`CFG_EN_HI:`CFG_EN_LO] != `CFG_DISABLE_CODE);

	// read data for one five-bit register address
	function [`REG_DATA_W-1:0] read_mux;
		input [`REG_ADDR_W-1:0] addr;
		input [`REG_DATA_W-1:0] guard;
		input [`REG_DATA_W-1:0] cfg;
		begin
			case (addr)
				`ADDR_GUARD: read_mux = guard;
				// configuration reads work whether locked or not
				`ADDR_CONFIG: read_mux = cfg;
				// kick is write only and reads as zero
				`ADDR_KICK: read_mux = `READ_ZERO;
				// reserved slots and unused addresses read zero
				default: read_mux = `READ_ZERO;
			endcase
		end
	endfunction

	// next guard value; spi wins when both front ends write at once
	always @* begin
		guard_d = guard_q;
		if (spi_wr && (spi_addr == `ADDR_GUARD)) begin
			guard_d = spi_wdata;
		end else if (i2c_wr && (i2c_addr == `ADDR_GUARD)) begin
			guard_d = i2c_wdata;
		end
	end

	// next configuration value, gated by the lock
	// the lock is judged on the guard before this cycle's write, so a
	// key and a configuration write in the same cycle stays locked
	always @* begin
		config_d = config_q;
		if (unlocked) begin
			if (spi_wr && (spi_addr == `ADDR_CONFIG)) begin
				config_d = spi_wdata;
			end else if (i2c_wr && (i2c_addr == `ADDR_CONFIG)) begin
				config_d = i2c_wdata;
			end
		end else begin
			// locked: the write is dropped without any error flag
			config_d = config_q;
		end
	end

	// kick bit is set by a write of one and clears on the next edge
	always @* begin
		kick_d = `KICK_RESET;
		if (spi_wr && (spi_addr == `ADDR_KICK)) begin
			kick_d = spi_wdata[`KICK_BIT];
		end else if (i2c_wr && (i2c_addr == `ADDR_KICK)) begin
			kick_d = i2c_wdata[`KICK_BIT];
		end
	end

	// guard and kick sit on the regulator power-on reset
	always @(posedge sys_clk or negedge regulator_one_power_on_reset_n) begin
		if (!regulator_one_power_on_reset_n) begin
			guard_q <= `GUARD_RESET;
			kick_q <= `KICK_RESET;
		end else begin
			guard_q <= guard_d;
			kick_q <= kick_d;
		end
	end

	// configuration sits on the supply power-on reset
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			config_q <= `CONFIG_RESET;
		end else begin
			config_q <= config_d;
		end
	end

	// read answers and status flags, one cycle after the request
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			spi_ack_q <= 1'b0;
			spi_rdata_q <= `READ_ZERO;
			i2c_ack_q <= 1'b0;
			i2c_rdata_q <= `READ_ZERO;
			config_unlocked_q <= 1'b0;
			watchdog_enabled_q <= 1'b0;
		end else begin
			spi_ack_q <= spi_req;
			i2c_ack_q <= i2c_req;
			// data shows the value before any write of the same cycle
			if (spi_req) begin
				spi_rdata_q <= read_mux(spi_addr, guard_q, config_q);
			end else begin
				spi_rdata_q <= `READ_ZERO;
			end
			if (i2c_req) begin
				i2c_rdata_q <= read_mux(i2c_addr, guard_q, config_q);
			end else begin
				i2c_rdata_q <= `READ_ZERO;
			end
			config_unlocked_q <= unlocked;
			watchdog_enabled_q <= run;
		end
	end

	// timeout mode period lookup
	always @* begin
		case (config_q[`CFG_TOUT_HI:`CFG_TOUT_LO])
			3'h0: tout_ms = `TOUT_MS_0;
			3'h1: tout_ms = `TOUT_MS_1;
			3'h2: tout_ms = `TOUT_MS_2;
			3'h3: tout_ms = `TOUT_MS_3;
			3'h4: tout_ms = `TOUT_MS_4;
			3'h5: tout_ms = `TOUT_MS_5;
			3'h6: tout_ms = `TOUT_MS_6;
			default: tout_ms = `TOUT_MS_7;
		endcase
	end

	// window mode period lookup
	always @* begin
		case (config_q[`CFG_WIN_HI:`CFG_WIN_LO])
			3'h0: win_ms = `WIN_MS_0;
			3'h1: win_ms = `WIN_MS_1;
			3'h2: win_ms = `WIN_MS_2;
			3'h3: win_ms = `WIN_MS_3;
			3'h4: win_ms = `WIN_MS_4;
			3'h5: win_ms = `WIN_MS_5;
			3'h6: win_ms = `WIN_MS_6;
			default: win_ms = `WIN_MS_7;
		endcase
	end

	// the open half begins at half the window period
	assign period_ms = window_mode ? win_ms : tout_ms;
	assign open_ms = window_mode ? {1'b0, win_ms[`MS_W-1:1]} : {`MS_W{1'b0}};

	// millisecond timer; exact cycle counts stay inside the tolerance
	watchdog_period_timer #(
		.CYCLES_PER_MS(CYCLES_PER_MS),
		.PRESCALE_W(`PRESCALE_W),
		.MS_W(`MS_W)
	) u_timer (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.run(run),
		.window_mode(window_mode),
		.restart(kick_q),
		.period_ms(period_ms),
		.open_ms(open_ms),
		.expired_q(watchdog_expired_q),
		.early_q(watchdog_early_q),
		.window_open_q(window_open_q)
	);

endmodule

// ===== bench/host_port_model.sv
`timescale 1ns/1ps
// front-end host on one register port, one request per call
module host_port_model (
	input wire clk,
	input wire ack,
	input wire [7:0] rdata,
	output reg req,
	output reg we,
	output reg [4:0] addr,
	output reg [7:0] wdata
);
	initial begin
		req = 1'b0;
		we = 1'b0;
		addr = 5'h00;
		wdata = 8'h00;
	end
	// request stands one cycle; answer taken a cycle later
	task xfer(input w, input [4:0] a, input [7:0] d, output [7:0] q);
		begin
			@(negedge clk);
			req = 1'b1;
			we = w;
			addr = a;
			wdata = d;
			@(negedge clk);
			req = 1'b0;
			// a missing answer must never look like data
			q = ack ? rdata : 8'hxx;
			// released lines flip so stale values are never trusted
			addr = ~addr;
			wdata = ~wdata;
		end
	endtask
endmodule

// ===== bench/watchdog_config_props.sv
`timescale 1ns/1ps
`include "watchdog_regs_map.vh"
// passive watcher on the register ports and timer flags
module watchdog_config_props (
	input wire sys_clk,
	input wire nrst,
	input wire regulator_one_power_on_reset_n,
	input wire window_mode,
	input wire spi_req,
	input wire spi_we,
	input wire [`REG_ADDR_W-1:0] spi_addr,
	input wire [`REG_DATA_W-1:0] spi_wdata,
	input wire spi_ack_q,
	input wire [`REG_DATA_W-1:0] spi_rdata_q,
	input wire i2c_req,
	input wire i2c_we,
	input wire i2c_ack_q,
	input wire config_unlocked_q,
	input wire watchdog_enabled_q,
	input wire watchdog_expired_q,
	input wire watchdog_early_q,
	input wire window_open_q
);
	// either reset clears state, so both silence the checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst || !regulator_one_power_on_reset_n);
	// an i2c write in the same cycle could move the config
	wire i2c_wr = i2c_req && i2c_we;
	wire cfg_rd = spi_req && !spi_we && spi_addr == `ADDR_CONFIG;
	sequence s_guard_wr;
		spi_req && spi_we && spi_addr == `ADDR_GUARD;
	endsequence
	property p_unlock;
		s_guard_wr ##0 spi_wdata == `GUARD_KEY |-> ##2 config_unlocked_q;
	endproperty
	a_unlock: assert property (p_unlock) else $error("no unlock");
	property p_lock;
		s_guard_wr ##0 spi_wdata != `GUARD_KEY |-> ##2 !config_unlocked_q;
	endproperty
	a_lock: assert property (p_lock) else $error("no lock");
	property p_spi_ack;
		spi_ack_q == $past(spi_req) && (spi_ack_q || spi_rdata_q == 8'h00);
	endproperty
	a_spi_ack: assert property (p_spi_ack) else $error("spi ack");
	property p_i2c_ack;
		i2c_req |=> i2c_ack_q;
	endproperty
	a_i2c_ack: assert property (p_i2c_ack) else $error("i2c ack");
	property p_kick_rd;
		spi_req && !spi_we && spi_addr == `ADDR_KICK |=> spi_rdata_q == 8'h00;
	endproperty
	a_kick_rd: assert property (p_kick_rd) else $error("kick read");
	property p_enable;
		$past(cfg_rd && !i2c_wr) |->
			watchdog_enabled_q == (spi_rdata_q[7:6] != `CFG_DISABLE_CODE);
	endproperty
	a_enable: assert property (p_enable) else $error("enable");
	property p_quiet;
		!watchdog_enabled_q [*3] |-> !watchdog_expired_q && !window_open_q;
	endproperty
	a_quiet: assert property (p_quiet) else $error("quiet");
	property p_pulse;
		watchdog_expired_q |=> !watchdog_expired_q;
	endproperty
	a_pulse: assert property (p_pulse) else $error("expiry");
	property p_early;
		watchdog_early_q |-> window_mode;
	endproperty
	a_early: assert property (p_early) else $error("early");
endmodule

// ===== bench/watchdog_config_registers_bench.sv
`timescale 1ns/1ps
`include "watchdog_regs_map.vh"
module watchdog_config_registers_bench;
	localparam cpm = 4; // short millisecond keeps all eight codes brief
	localparam spi = 1'b0;
	localparam i2c = 1'b1;
	// nominal periods in ms, code 0 in the low slot
	localparam [127:0] tms = {16'd4000, 16'd2000, 16'd1000, 16'd800,
		16'd480, 16'd320, 16'd160, 16'd80};
	localparam [127:0] wms = {16'd400, 16'd320, 16'd240, 16'd160,
		16'd120, 16'd80, 16'd40, 16'd10};
	reg sys_clk = 1'b0;
	reg nrst = 1'b0;
	reg regulator_one_power_on_reset_n = 1'b0;
	reg window_mode = 1'b0;
	wire spi_req, spi_we, spi_ack_q, i2c_req, i2c_we, i2c_ack_q;
	wire [4:0] spi_addr, i2c_addr;
	wire [7:0] spi_wdata, i2c_wdata, spi_rdata_q, i2c_rdata_q;
	wire config_unlocked_q, watchdog_enabled_q, watchdog_expired_q;
	wire watchdog_early_q, window_open_q;
	integer failures = 0;
	integer check_count = 0;
	integer cyc = 0;
	integer t, t_open, i, n;
	reg [7:0] q;
	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	watchdog_config_registers #(.CYCLES_PER_MS(cpm)) DUT (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.regulator_one_power_on_reset_n(regulator_one_power_on_reset_n),
		.window_mode(window_mode),
		.spi_req(spi_req),
		.spi_we(spi_we),
		.spi_addr(spi_addr),
		.spi_wdata(spi_wdata),
		.spi_ack_q(spi_ack_q),
		.spi_rdata_q(spi_rdata_q),
		.i2c_req(i2c_req),
		.i2c_we(i2c_we),
		.i2c_addr(i2c_addr),
		.i2c_wdata(i2c_wdata),
		.i2c_ack_q(i2c_ack_q),
		.i2c_rdata_q(i2c_rdata_q),
		.config_unlocked_q(config_unlocked_q),
		.watchdog_enabled_q(watchdog_enabled_q),
		.watchdog_expired_q(watchdog_expired_q),
		.watchdog_early_q(watchdog_early_q),
		.window_open_q(window_open_q)
	);
	host_port_model spi_host (.clk(sys_clk), .ack(spi_ack_q),
		.rdata(spi_rdata_q), .req(spi_req), .we(spi_we),
		.addr(spi_addr), .wdata(spi_wdata));
	host_port_model i2c_host (.clk(sys_clk), .ack(i2c_ack_q),
		.rdata(i2c_rdata_q), .req(i2c_req), .we(i2c_we),
		.addr(i2c_addr), .wdata(i2c_wdata));
	task stop_test;
		begin
			$display("checks %0d failures %0d", check_count, failures);
			if (failures == 0 && check_count > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("Error %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	// cycle counts pass within a quarter of nominal
	task chk_rng(input [47:0] nm, input integer e, input integer g);
		begin
			check_count = check_count + 1;
			if (g < e - e / 4 || g > e + e / 4) begin
				failures = failures + 1;
				$display("Error %0s exp %0d got %0d", nm, e, g);
			end
		end
	endtask
	task acc(input p, input w, input [4:0] a, input [7:0] d);
		if (p)
			i2c_host.xfer(w, a, d, q);
		else
			spi_host.xfer(w, a, d, q);
	endtask
	task rdc(input p, input [4:0] a, input [7:0] e);
		begin
			acc(p, 1'b0, a, 8'h00);
			chk("rdata", e, q);
		end
	endtask
	// kick, then time the window opening and the expiry after it
	task run_period(input integer per, input integer half);
		begin
			acc(spi, 1'b1, `ADDR_KICK, 8'h01);
			t = 0;
			t_open = 0;
			while (watchdog_expired_q !== 1'b1 && t < 50000) begin
				@(negedge sys_clk);
				t = t + 1;
				// first cycle the open half shows; in window mode expiry shuts it again
				if (window_open_q === 1'b1 && t_open == 0)
					t_open = t;
			end
			chk_rng("period", per * cpm, t);
			if (half > 0)
				chk_rng("open", half * cpm, t_open);
		end
	endtask
	// cut a hang short well past the expected 43k cycles
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			failures = failures + 1;
			stop_test;
		end
	end
	initial begin
		repeat (2) @(negedge sys_clk);
		nrst = 1'b1;
		regulator_one_power_on_reset_n = 1'b1;
		for (i = 0; i < 5; i = i + 1)
			rdc(spi, i[4:0], (i == 3) ? 8'h09 : 8'h00);
		rdc(i2c, 5'h1f, 8'h00);
		acc(spi, 1'b1, `ADDR_CONFIG, 8'h41);
		rdc(spi, `ADDR_CONFIG, 8'h09);
		acc(spi, 1'b1, `ADDR_GUARD, 8'h5b);
		acc(i2c, 1'b1, `ADDR_CONFIG, 8'h41);
		rdc(i2c, `ADDR_CONFIG, 8'h09);
		chk("lock", 8'h00, {7'h00, config_unlocked_q});
		acc(spi, 1'b1, `ADDR_GUARD, 8'h5a);
		rdc(i2c, `ADDR_GUARD, 8'h5a);
		chk("unlock", 8'h01, {7'h00, config_unlocked_q});
		for (i = 0; i < 8; i = i + 1) begin
			acc(i2c, 1'b1, `ADDR_CONFIG, {i[4:0], 3'h0});
			rdc(spi, `ADDR_CONFIG, {i[4:0], 3'h0});
			run_period(tms[16*i +: 16], 0);
		end
		window_mode = 1'b1;
		for (i = 0; i < 8; i = i + 1) begin
			acc(spi, 1'b1, `ADDR_CONFIG, {5'h00, i[2:0]});
			run_period(wms[16*i +: 16], wms[16*i +: 16] / 2);
		end
		// right after an expiry the window is still shut
		acc(spi, 1'b1, `ADDR_KICK, 8'h01);
		n = 0;
		repeat (4) @(negedge sys_clk) n = n + watchdog_early_q;
		chk("early", 8'h01, n[7:0]);
		acc(i2c, 1'b1, `ADDR_CONFIG, 8'h49);
		n = 0;
		repeat (2000) @(negedge sys_clk) n = n + watchdog_expired_q;
		chk("expiry", 8'h00, n[7:0]);
		chk("en", 8'h00, {7'h00, watchdog_enabled_q});
		regulator_one_power_on_reset_n = 1'b0;
		@(negedge sys_clk);
		regulator_one_power_on_reset_n = 1'b1;
		rdc(spi, `ADDR_GUARD, 8'h00);
		chk("relock", 8'h00, {7'h00, config_unlocked_q});
		acc(spi, 1'b1, `ADDR_CONFIG, 8'h00);
		rdc(spi, `ADDR_CONFIG, 8'h49);
		stop_test;
	end
endmodule
bind watchdog_config_registers watchdog_config_props props (
	.sys_clk(sys_clk),
	.nrst(nrst),
	.regulator_one_power_on_reset_n(regulator_one_power_on_reset_n),
	.window_mode(window_mode),
	.spi_req(spi_req),
	.spi_we(spi_we),
	.spi_addr(spi_addr),
	.spi_wdata(spi_wdata),
	.spi_ack_q(spi_ack_q),
	.spi_rdata_q(spi_rdata_q),
	.i2c_req(i2c_req),
	.i2c_we(i2c_we),
	.i2c_ack_q(i2c_ack_q),
	.config_unlocked_q(config_unlocked_q),
	.watchdog_enabled_q(watchdog_enabled_q),
	.watchdog_expired_q(watchdog_expired_q),
	.watchdog_early_q(watchdog_early_q),
	.window_open_q(window_open_q)
);
